/* File: hw/emb_pkg.sv */
package emb_pkg;

    // ========================================================================
    // Machine cycle layout
    // ========================================================================
    // A machine cycle has six states, split into two halves of three states.
    // Each half carries one address latch slot and one code read slot.
    localparam int          STATES_PER_CYCLE = 6;
    localparam int          STATES_PER_HALF  = 3;
    localparam logic [2:0]  ST_FIRST         = 3'h0;
    localparam logic [2:0]  ST_HALF_END      = 3'h2;
    localparam logic [2:0]  ST_SECOND_HALF   = 3'h3;
    localparam logic [2:0]  ST_LAST          = 3'h5;
    localparam logic [1:0]  LOC_ADDR         = 2'h0;
    localparam logic [1:0]  LOC_SAMPLE       = 2'h2;

    // Oscillator clocks per state in each machine cycle mode.
    localparam int          CLK_PER_STATE_FAST = 1;
    localparam int          CLK_PER_STATE_SLOW = 2;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [7:0]  LOW_PORT_RESET  = 8'hFF;
    localparam logic [7:0]  HIGH_PORT_RESET = 8'hFF;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        EMB_IDLE,
        EMB_FETCH,
        EMB_DATA0,
        EMB_DATA1
    } emb_half_type;

    typedef struct packed {
        logic        write;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emb_data_req_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } emb_pin_type;

endpackage

/* File: hw/emb_state_timer.sv */
module emb_state_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       sixClockMode,
    output logic      [2:0] stateIdx,
    output logic            stateLast
);

    // ========================================================================
    // State sequencer
    // ========================================================================
    // The mode is taken only at a machine cycle boundary so a cycle never
    // mixes one and two clock states.
    logic [2:0] state_ff;
    logic       sub_ff;
    logic       sixMode_ff;

    assign stateIdx  = state_ff;
    assign stateLast = run && (sixMode_ff || sub_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff   <= emb_pkg::ST_FIRST;
            sub_ff     <= 1'b0;
            sixMode_ff <= 1'b0;
        end else if (!run) begin
            sixMode_ff <= sixClockMode;
        end else if (stateLast) begin
            sub_ff <= 1'b0;
            if (state_ff == emb_pkg::ST_LAST) begin
                state_ff   <= emb_pkg::ST_FIRST;
                sixMode_ff <= sixClockMode;
            end else begin
                state_ff <= state_ff + 3'h1;
            end
        end else begin
            sub_ff <= 1'b1;
        end
    end

endmodule

/* File: hw/emb_low_port_pad.sv */
module emb_low_port_pad #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] busVal,
    input  wire logic             busMode,
    input  wire logic             busOe,
    input  wire logic [WIDTH-1:0] gpioLatch,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOe
);

    // ========================================================================
    // Per-pin drive
    // ========================================================================
    // On the bus both levels are driven hard; as a general port the pin can
    // only pull low and a latched one leaves it floating as an input.
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        assign pinOut[i] = busMode ? busVal[i] : 1'b0;
        assign pinOe[i]  = busMode ? busOe : ~gpioLatch[i];
    end

endmodule

/* File: hw/emb_bus_port.sv */
// How it works
// - Low port multiplexes address and data, driven strong.
// - Low general port written one floats.
// - High port emits high address byte.
// - Short pointer moves emit high port latch.
// - Address latch strobe pulses continuously, twice per cycle.
// - Data access omits one address latch pulse.
// - Inhibit bit limits latch strobe to data moves.
// - External code reads strobe twice per cycle.
// - Data access skips two code strobes.
// - Select pin low chooses external code.
// - Select pin sampled once at reset release.
// - Select high latched means never external fetch.
// - Active low data write and read strobes.
// - Machine cycle is six or twelve clocks.
module emb_bus_port (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      sixClockMode,
    input  wire logic                      aleInhibit,
    input  wire logic                      codeSourceSelect,
    input  wire logic                      fetchReq,
    input  wire logic               [15:0] fetchAddr,
    output logic                           fetchAck,
    output logic                           fetchDone,
    output logic                     [7:0] codeByte,
    input  wire logic                      dataReq,
    input  wire emb_pkg::emb_data_req_type dataPkt,
    output logic                           dataAck,
    output logic                           dataDone,
    output logic                     [7:0] dataByte,
    input  wire logic                [7:0] lowPortLatch,
    input  wire logic                [7:0] highPortLatch,
    input  wire logic                [7:0] lowAddrDataPortIn,
    output emb_pkg::emb_pin_type           lowAddrDataPort,
    output emb_pkg::emb_pin_type           highAddrPort,
    output logic                           addrLatchStrobe,
    output logic                           codeReadStrobeN,
    output logic                           dataWriteStrobeN,
    output logic                           dataReadStrobeN,
    output logic                           extCodeActive
);

    // ========================================================================
    // Code source latch
    // ========================================================================
    // The select pin is caught by the first clock after reset release, so
    // the asynchronous reset itself only ever loads constants.
    logic started_ff;
    logic extCode_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            started_ff <= 1'b0;
            extCode_ff <= 1'b0;
        end else if (!started_ff) begin
            started_ff <= 1'b1;
            extCode_ff <= ~codeSourceSelect;
        end
    end

    assign extCodeActive = extCode_ff;

    // ========================================================================
    // State timing
    // ========================================================================
    logic [2:0] stateIdx;
    logic       stateLast;
    logic [1:0] localState;
    logic       halfEnd;
    logic       sampleClk;

    emb_state_timer u_timer (
        .clk          (clk),
        .rst          (rst),
        .run          (started_ff),
        .sixClockMode (sixClockMode),
        .stateIdx     (stateIdx),
        .stateLast    (stateLast)
    );

    assign localState = (stateIdx >= emb_pkg::ST_SECOND_HALF)
                      ? 2'(stateIdx - emb_pkg::ST_SECOND_HALF)
                      : stateIdx[1:0];

    assign halfEnd = stateLast && (stateIdx == emb_pkg::ST_HALF_END ||
                                   stateIdx == emb_pkg::ST_LAST);

    assign sampleClk = stateLast && (localState == emb_pkg::LOC_SAMPLE);

    // ========================================================================
    // Half cycle scheduling
    // ========================================================================
    // A data access takes two halves of a machine cycle. Its first half
    // latches the data address, its second carries the read or write strobe,
    // so neither half holds a code read.
    emb_pkg::emb_half_type halfKind_ff;
    emb_pkg::emb_half_type nxt_halfKind;

    always_comb begin
        if (halfKind_ff == emb_pkg::EMB_DATA0) begin
            nxt_halfKind = emb_pkg::EMB_DATA1;
        end else if (dataReq) begin
            nxt_halfKind = emb_pkg::EMB_DATA0;
        end else if (extCode_ff) begin
            nxt_halfKind = emb_pkg::EMB_FETCH;
        end else begin
            nxt_halfKind = emb_pkg::EMB_IDLE;
        end
    end

    assign dataAck  = halfEnd && (halfKind_ff != emb_pkg::EMB_DATA0) && dataReq;
    assign fetchAck = halfEnd && (nxt_halfKind == emb_pkg::EMB_FETCH) && fetchReq;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfKind_ff <= emb_pkg::EMB_IDLE;
        end else if (halfEnd) begin
            halfKind_ff <= nxt_halfKind;
        end
    end

    // ========================================================================
    // Access capture
    // ========================================================================
    // In external code mode every free half runs a code read; when the core
    // has no fetch pending the read is still issued but its byte is dropped.
    logic [15:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic        write_ff;
    logic        wide_ff;
    logic        fetchLive_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff      <= emb_pkg::ADDR_RESET;
            wdata_ff     <= emb_pkg::BYTE_RESET;
            write_ff     <= 1'b0;
            wide_ff      <= 1'b0;
            fetchLive_ff <= 1'b0;
        end else if (halfEnd) begin
            if (nxt_halfKind == emb_pkg::EMB_DATA0) begin
                addr_ff      <= dataPkt.addr;
                wdata_ff     <= dataPkt.wdata;
                write_ff     <= dataPkt.write;
                wide_ff      <= dataPkt.wide;
                fetchLive_ff <= 1'b0;
            end else if (nxt_halfKind == emb_pkg::EMB_FETCH) begin
                addr_ff      <= fetchAddr;
                write_ff     <= 1'b0;
                wide_ff      <= 1'b1;
                fetchLive_ff <= fetchReq;
            end else if (nxt_halfKind == emb_pkg::EMB_IDLE) begin
                write_ff     <= 1'b0;
                fetchLive_ff <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Read data return
    // ========================================================================
    // Bytes are taken on the last clock of the strobe, while the strobe is
    // still low and the memory is still driving the low port.
    logic       fetchDone_ff;
    logic [7:0] codeByte_ff;
    logic       dataDone_ff;
    logic [7:0] dataByte_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetchDone_ff <= 1'b0;
            codeByte_ff  <= emb_pkg::BYTE_RESET;
        end else begin
            fetchDone_ff <= sampleClk && fetchLive_ff &&
                            (halfKind_ff == emb_pkg::EMB_FETCH);
            if (sampleClk && fetchLive_ff && halfKind_ff == emb_pkg::EMB_FETCH) begin
                codeByte_ff <= lowAddrDataPortIn;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataDone_ff <= 1'b0;
            dataByte_ff <= emb_pkg::BYTE_RESET;
        end else begin
            dataDone_ff <= sampleClk && (halfKind_ff == emb_pkg::EMB_DATA1);
            if (sampleClk && halfKind_ff == emb_pkg::EMB_DATA1 && !write_ff) begin
                dataByte_ff <= lowAddrDataPortIn;
            end
        end
    end

    assign fetchDone = fetchDone_ff;
    assign codeByte  = codeByte_ff;
    assign dataDone  = dataDone_ff;
    assign dataByte  = dataByte_ff;

    // ========================================================================
    // Strobes
    // ========================================================================
    // The address is held through the first state only, so external logic
    // latches it as the strobe falls at the end of that state.
    logic addrPhase;
    logic dataHalf;

    assign addrPhase = (localState == emb_pkg::LOC_ADDR) &&
                       (halfKind_ff == emb_pkg::EMB_FETCH ||
                        halfKind_ff == emb_pkg::EMB_DATA0);
    assign dataHalf  = (halfKind_ff == emb_pkg::EMB_DATA0 ||
                        halfKind_ff == emb_pkg::EMB_DATA1);

    always_comb begin
        addrLatchStrobe = 1'b0;
        if (started_ff && localState == emb_pkg::LOC_ADDR) begin
            if (aleInhibit) begin
                addrLatchStrobe = (halfKind_ff == emb_pkg::EMB_DATA0);
            end else begin
                addrLatchStrobe = (halfKind_ff != emb_pkg::EMB_DATA1);
            end
        end
    end

    assign codeReadStrobeN  = !(halfKind_ff == emb_pkg::EMB_FETCH &&
                                localState != emb_pkg::LOC_ADDR);
    assign dataReadStrobeN  = !(halfKind_ff == emb_pkg::EMB_DATA1 && !write_ff);
    assign dataWriteStrobeN = !(halfKind_ff == emb_pkg::EMB_DATA1 && write_ff);

    // ========================================================================
    // Low address and data port
    // ========================================================================
    // Write data goes out right after the address and stays through the
    // whole strobe half, giving the memory setup and hold around the strobe.
    logic       lowBusMode;
    logic       lowBusOe;
    logic [7:0] lowBusVal;
    logic [7:0] lowPinOut;
    logic [7:0] lowPinOe;

    assign lowBusMode = (halfKind_ff != emb_pkg::EMB_IDLE);
    assign lowBusOe   = addrPhase ||
                        (write_ff && (halfKind_ff == emb_pkg::EMB_DATA1 ||
                                      halfKind_ff == emb_pkg::EMB_DATA0));
    assign lowBusVal  = addrPhase ? addr_ff[7:0] : wdata_ff;

    emb_low_port_pad #(
        .WIDTH (8)
    ) u_low_pad (
        .busVal    (lowBusVal),
        .busMode   (lowBusMode),
        .busOe     (lowBusOe),
        .gpioLatch (lowPortLatch),
        .pinOut    (lowPinOut),
        .pinOe     (lowPinOe)
    );

    assign lowAddrDataPort.out = lowPinOut;
    assign lowAddrDataPort.oe  = lowPinOe;

    // ========================================================================
    // High address port
    // ========================================================================
    // Outside bus halves the port acts as a general port whose ones come
    // from the pull-ups, so only the zeros are driven.
    always_comb begin
        if (halfKind_ff == emb_pkg::EMB_IDLE) begin
            highAddrPort.out = highPortLatch;
            highAddrPort.oe  = ~highPortLatch;
        end else if (dataHalf && !wide_ff) begin
            highAddrPort.out = highPortLatch;
            highAddrPort.oe  = 8'hFF;
        end else begin
            highAddrPort.out = addr_ff[15:8];
            highAddrPort.oe  = 8'hFF;
        end
    end

endmodule

/* File: tb/emb_bus_port_asserts.sv */
module emb_bus_port_asserts (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 sixClockMode,
    input wire logic                 aleInhibit,
    input wire logic                 fetchAck,
    input wire logic                 fetchDone,
    input wire logic                 dataAck,
    input wire logic                 dataDone,
    input wire emb_pkg::emb_pin_type lowAddrDataPort,
    input wire logic                 addrLatchStrobe,
    input wire logic                 codeReadStrobeN,
    input wire logic                 dataWriteStrobeN,
    input wire logic                 dataReadStrobeN,
    input wire logic                 extCodeActive
);
    timeunit 1ns;
    timeprecision 1ps;

    logic armed_ff;

    // ========================================================================
    // Helper logic
    // ========================================================================
    // Marks that the code source has already been latched after reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_ff <= 1'h0;
        end else begin
            armed_ff <= 1'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ========================================================================
    // Properties
    // ========================================================================
    a_reset_quiet: assert property (disable iff (1'h0) rst |-> lowAddrDataPort.oe == 8'h00
        && !addrLatchStrobe && codeReadStrobeN && dataReadStrobeN && dataWriteStrobeN)
        else $error("outputs not idle during reset");
    a_select_held: assert property (armed_ff |=> $stable(extCodeActive))
        else $error("code source changed after reset");
    a_no_int_code: assert property (!extCodeActive |-> codeReadStrobeN)
        else $error("code strobe with internal code");
    a_data_no_code: assert property (!(dataReadStrobeN && dataWriteStrobeN) |-> codeReadStrobeN)
        else $error("code strobe during data access");
    a_ale_skip: assert property (!(dataReadStrobeN && dataWriteStrobeN) |-> !addrLatchStrobe)
        else $error("latch strobe during data strobe");
    a_ale_narrow: assert property (addrLatchStrobe && sixClockMode |=> !addrLatchStrobe)
        else $error("latch strobe wider than one clock");
    a_ale_steady: assert property (addrLatchStrobe && sixClockMode && !aleInhibit
        ##3 (dataReadStrobeN && dataWriteStrobeN) |-> addrLatchStrobe)
        else $error("latch strobe missing");
    a_ale_inhibit: assert property (aleInhibit && sixClockMode && addrLatchStrobe
        |-> ##3 !(dataReadStrobeN && dataWriteStrobeN))
        else $error("latch strobe outside data move");
    a_code_twice: assert property (extCodeActive && sixClockMode && $fell(codeReadStrobeN)
        |-> ##[1:9] $fell(codeReadStrobeN))
        else $error("code strobe gap too long");
    a_read_width: assert property (sixClockMode && $fell(dataReadStrobeN)
        |-> !dataReadStrobeN [*3] ##1 dataReadStrobeN)
        else $error("read strobe width wrong");
    a_write_drives: assert property (!dataWriteStrobeN |-> lowAddrDataPort.oe == 8'hFF)
        else $error("low port not driven during write");
    a_fetch_answer: assert property (fetchAck && sixClockMode |-> ##4 fetchDone)
        else $error("fetch answer late");
    a_data_answer: assert property (dataAck && sixClockMode |-> ##7 dataDone)
        else $error("data answer late");
endmodule

bind emb_bus_port emb_bus_port_asserts emb_bus_port_asserts_i (.clk, .rst, .sixClockMode,
    .aleInhibit, .fetchAck, .fetchDone, .dataAck, .dataDone, .lowAddrDataPort,
    .addrLatchStrobe, .codeReadStrobeN, .dataWriteStrobeN, .dataReadStrobeN, .extCodeActive);

/* File: tb/emb_ext_mem.sv */
module emb_ext_mem (
    input  wire logic       clk,
    input  wire logic       addrLatchStrobe,
    input  wire logic       codeReadStrobeN,
    input  wire logic       dataReadStrobeN,
    input  wire logic       dataWriteStrobeN,
    input  wire logic [7:0] lowPins,
    input  wire logic [7:0] highPins,
    output logic      [7:0] memOut,
    output logic            memOe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  lowAddr;
    logic [7:0]  readVal;
    logic [7:0]  dataMem [65536];
    logic [15:0] fullAddr;

    assign fullAddr = {highPins, lowAddr};

    initial begin
        for (int i = 0; i < 65536; i++) dataMem[i] = 8'h00;
    end

    // The latch and the memory take the port on the clock edge that ends each
    // state, while the strobe and the port still show that state's values.
    always @(posedge clk) begin
        if (addrLatchStrobe) begin
            lowAddr <= lowPins;
        end
        if (!dataWriteStrobeN) begin
            dataMem[fullAddr] <= lowPins;
        end
    end

    // Code bytes are the two address bytes combined; unwritten data reads zero.
    always_comb begin
        readVal = fullAddr[7:0] ^ fullAddr[15:8];
        if (codeReadStrobeN) begin
            readVal = dataMem[fullAddr];
        end
        memOe = !codeReadStrobeN || !dataReadStrobeN;
        // A released bus shows the inverse, never a stale copy.
        memOut = memOe ? readVal : ~readVal;
    end
endmodule

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic isData, write, wide;
        logic [15:0] addr;
        logic [7:0] wdata, hiLatch, expByte;
    } emb_row_type;

    logic clk, rst, sixClockMode, aleInhibit, codeSourceSelect, fetchReq, fetchAck, fetchDone;
    logic dataReq, dataAck, dataDone, addrLatchStrobe, codeReadStrobeN, extCodeActive;
    logic dataWriteStrobeN, dataReadStrobeN, memOe;
    logic [15:0] fetchAddr;
    logic [7:0] codeByte, dataByte, lowPortLatch, highPortLatch, lowPins, highPins, memOut;
    emb_pkg::emb_data_req_type dataPkt;
    emb_pkg::emb_pin_type lowAddrDataPort, highAddrPort;
    int mismatches, num_checks, a, c, k;

    emb_row_type rows [7] = '{
        '{1'h0, 1'h0, 1'h0, 16'h1234, 8'h00, 8'hFF, 8'h26},
        '{1'h1, 1'h1, 1'h1, 16'h1234, 8'hA5, 8'hFF, 8'h00},
        '{1'h1, 1'h0, 1'h1, 16'h1234, 8'h00, 8'hFF, 8'hA5},
        '{1'h1, 1'h1, 1'h0, 16'h0056, 8'h3C, 8'h77, 8'h00},
        '{1'h1, 1'h0, 1'h0, 16'h0056, 8'h00, 8'h77, 8'h3C},
        '{1'h1, 1'h0, 1'h1, 16'h7756, 8'h00, 8'h00, 8'h3C},
        '{1'h0, 1'h0, 1'h0, 16'hFF00, 8'h00, 8'h00, 8'hFF}
    };

    assign lowPins = (lowAddrDataPort.oe & lowAddrDataPort.out) | (~lowAddrDataPort.oe & memOut);
    assign highPins = (highAddrPort.oe & highAddrPort.out) | ~highAddrPort.oe;

    emb_bus_port emb_bus_port_i (.clk, .rst, .sixClockMode, .aleInhibit, .codeSourceSelect,
        .fetchReq, .fetchAddr, .fetchAck, .fetchDone, .codeByte, .dataReq, .dataPkt, .dataAck,
        .dataDone, .dataByte, .lowPortLatch, .highPortLatch, .lowAddrDataPortIn(lowPins),
        .lowAddrDataPort, .highAddrPort, .addrLatchStrobe, .codeReadStrobeN, .dataWriteStrobeN,
        .dataReadStrobeN, .extCodeActive);
    emb_ext_mem emb_ext_mem_i (.clk, .addrLatchStrobe, .codeReadStrobeN, .dataReadStrobeN,
        .dataWriteStrobeN, .lowPins, .highPins, .memOut, .memOe);

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic bound(input int n);
        if (n >= 60) begin
            mismatches++;
            give_verdict();
        end
    endtask

    task automatic doReset(input int hold, input logic six, input logic inh, input logic sel);
        @(posedge clk);
        rst <= 1'h1;
        sixClockMode <= six;
        aleInhibit <= inh;
        codeSourceSelect <= sel;
        repeat (hold) @(posedge clk);
        check({addrLatchStrobe, codeReadStrobeN, dataReadStrobeN, dataWriteStrobeN}, 16'h7);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        check(extCodeActive, !sel);
    endtask

    task automatic access(input emb_row_type r);
        int n;
        logic [7:0] hiSeen;
        hiSeen = 8'h00;
        n = 0;
        @(posedge clk);
        highPortLatch <= r.hiLatch;
        dataPkt <= '{r.write, r.wide, r.addr, r.wdata};
        fetchAddr <= r.addr;
        dataReq <= r.isData;
        fetchReq <= !r.isData;
        do begin
            @(negedge clk);
            n++;
        end while (!(r.isData ? dataAck : fetchAck) && n < 60);
        bound(n);
        @(posedge clk);
        dataReq <= 1'h0;
        fetchReq <= 1'h0;
        n = 0;
        while (!(r.isData ? dataDone : fetchDone) && n < 60) begin
            @(negedge clk);
            if (!dataReadStrobeN || !dataWriteStrobeN) hiSeen = highAddrPort.out;
            n++;
        end
        bound(n);
        if (r.isData) check(hiSeen, r.wide ? r.addr[15:8] : r.hiLatch);
        if (!r.write) check(r.isData ? dataByte : codeByte, r.expByte);
    endtask

    task automatic countAle(input int cycles, output int ales, output int codes, output int acks);
        logic prevAle;
        logic prevCode;
        ales = 0;
        codes = 0;
        acks = 0;
        prevAle = addrLatchStrobe;
        prevCode = codeReadStrobeN;
        repeat (cycles) begin
            @(negedge clk);
            if (addrLatchStrobe && !prevAle) ales++;
            if (!codeReadStrobeN && prevCode) codes++;
            if (fetchAck) acks++;
            prevAle = addrLatchStrobe;
            prevCode = codeReadStrobeN;
        end
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst, sixClockMode, aleInhibit, codeSourceSelect} = 4'hC;
        {fetchReq, dataReq, fetchAddr, dataPkt} = '0;
        {lowPortLatch, highPortLatch} = 16'hFFFF;
        mismatches = 0;
        num_checks = 0;
        doReset(5, 1'h1, 1'h0, 1'h0);
        codeSourceSelect <= 1'h1;
        for (int i = 0; i < 7; i++) access(rows[i]);
        countAle(60, a, c, k);
        check(16'(a), 16'h0014);
        check(16'(c), 16'h0014);
        check(extCodeActive, 1'h1);
        doReset(24, 1'h0, 1'h0, 1'h1);
        fetchReq <= 1'h1;
        countAle(120, a, c, k);
        fetchReq <= 1'h0;
        check(16'(a), 16'h0014);
        check(16'(c), 16'h0000);
        check(16'(k), 16'h0000);
        @(posedge clk);
        lowPortLatch <= 8'h5A;
        repeat (2) @(posedge clk);
        check(lowAddrDataPort.oe, 16'h00A5);
        check(lowAddrDataPort.out, 16'h0000);
        lowPortLatch <= 8'hFF;
        for (int i = 1; i < 3; i++) access(rows[i]);
        doReset(12, 1'h1, 1'h1, 1'h1);
        countAle(60, a, c, k);
        check(16'(a), 16'h0000);
        for (int i = 3; i < 5; i++) access(rows[i]);
        give_verdict();
    end
endmodule
